// ===== hw/timer_ccp_pkg.sv
package timer_ccp_pkg;
    localparam logic [11:0] OFF_ENABLE  = 12'h000;
    localparam logic [11:0] OFF_RUN     = 12'h004;
    localparam logic [11:0] OFF_CONTROL = 12'h008;
    localparam logic [11:0] OFF_MODE    = 12'h00c;
    localparam logic [11:0] OFF_FFCR    = 12'h010;
    localparam logic [11:0] OFF_CMP0    = 12'h014;
    localparam logic [11:0] OFF_CMP1    = 12'h018;
    localparam logic [11:0] OFF_CAP0    = 12'h01c;
    localparam logic [11:0] OFF_CAP1    = 12'h020;
    localparam logic [11:0] OFF_SNAP    = 12'h024;

    localparam int BIT_CH_EN     = 7;
    localparam int BIT_RUN       = 0;
    localparam int BIT_PRE_RUN   = 2;
    localparam int BIT_BUF_EN    = 7;
    localparam int BIT_SOFT_CAP  = 6;
    localparam int BIT_CLR_MATCH = 5;
    localparam int POS_CAP_MODE  = 3;
    localparam int POS_CLK_SEL   = 0;
    localparam int BIT_C1T1      = 5;
    localparam int BIT_C0T1      = 4;
    localparam int BIT_E1T1      = 3;
    localparam int BIT_E0T1      = 2;
    localparam int POS_FF_CTRL   = 0;

    localparam logic [7:0]  RST_ENABLE  = 8'h00;
    localparam logic [7:0]  RST_RUN     = 8'h00;
    localparam logic [7:0]  RST_CONTROL = 8'h00;
    localparam logic [7:0]  RST_MODE    = 8'h40;
    localparam logic [7:0]  RST_FFCR    = 8'h03;
    localparam logic [15:0] RST_CMP     = 16'h0000;

    localparam logic [2:0] CLK_EXT_PIN = 3'h0;
    localparam logic [2:0] CLK_PT1     = 3'h1;
    localparam logic [2:0] CLK_PT4     = 3'h2;
    localparam logic [2:0] CLK_PT16    = 3'h3;

    localparam logic [1:0] CAPM_OFF      = 2'h0;
    localparam logic [1:0] CAPM_RISE_FALL = 2'h1;
    localparam logic [1:0] CAPM_RISE_RISE = 2'h2;
    localparam logic [1:0] CAPM_RISE_M1   = 2'h3;

    localparam logic [1:0] FF_TOGGLE = 2'h0;
    localparam logic [1:0] FF_SET    = 2'h1;
    localparam logic [1:0] FF_CLEAR  = 2'h2;

    // prescaler tick periods in ref_clk cycles
    localparam logic [5:0] DIV_PT1  = 6'h02;
    localparam logic [5:0] DIV_PT4  = 6'h08;
    localparam logic [5:0] DIV_PT16 = 6'h20;
endpackage

// ===== hw/timer_capture_compare_ppg.sv
`timescale 1ns/100ps
// Notes on behaviour
// - run bit zero stops and clears counter
// - counter overflow raises overflow interrupt
// - two compare registers, equality gives match
// - compare buffers, off after reset, bit enables
// - buffers load compares on match one
// - stopped counter: compare writes act immediately
// - two-bit field selects capture moment
// - writing zero to soft capture latches counter
// - snapshot read returns live count, no side-effect
// - either match raises compare interrupt
// - output flop toggles on enabled events
// - control field: toggle, set, clear
// - output flop drives timer output pin
// - each capture raises its own interrupt
// - match zero/one give interrupt zero/one
// - event mode counts external pin rising edges
// - pulse mode toggles on both matches
// - pulse polarity set by flop initial state
// - three-bit field selects count clock
// - clear-enable clears on match one, else free
module timer_capture_compare_ppg
    import timer_ccp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_pin,
    output logic             timer_output_pin,
    output logic             overflow_irq,
    output logic             compare_irq,
    output logic             compare_zero_irq,
    output logic             compare_one_irq,
    output logic             capture_zero_irq,
    output logic             capture_one_irq
);
    logic [7:0]  channel_enable_reg_ff;
    logic [7:0]  run_control_reg_ff;
    logic [7:0]  channel_control_reg_ff;
    logic [7:0]  mode_select_reg_ff;
    logic [7:0]  toggle_flop_control_reg_ff;
    logic [15:0] compare_reg_zero_ff;
    logic [15:0] compare_reg_one_ff;
    logic [15:0] buffer_zero_ff;
    logic [15:0] buffer_one_ff;
    logic [15:0] capture_reg_zero_ff;
    logic [15:0] capture_reg_one_ff;
    logic [15:0] up_counter_ff;
    logic [5:0]  presc_ff;
    logic [2:0]  pin_sync_ff;
    logic        eq0_d_ff;
    logic        eq1_d_ff;
    logic        output_toggle_flop_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        ovf_ff;
    logic        cmp0_ff;
    logic        cmp1_ff;
    logic        cap0_ff;
    logic        cap1_ff;
    logic        clr_pend_ff;
    logic        cmp_any_ff;

    wire setup     = psel & ~penable & ~pready_ff;
    wire access    = psel & penable & pready_ff;
    wire wr        = access & pwrite;
    wire wr_run    = wr & (paddr == OFF_RUN);
    wire wr_ctl    = wr & (paddr == OFF_CONTROL);
    wire wr_mode   = wr & (paddr == OFF_MODE);
    wire wr_ffcr   = wr & (paddr == OFF_FFCR);
    wire wr_cmp0   = wr & (paddr == OFF_CMP0);
    wire wr_cmp1   = wr & (paddr == OFF_CMP1);
    wire mapped    = (paddr[1:0] == 2'h0) & (paddr <= OFF_SNAP);

    wire       ch_en    = channel_enable_reg_ff[BIT_CH_EN];
    wire       running  = ch_en & run_control_reg_ff[BIT_RUN];
    wire       pre_run  = ch_en & run_control_reg_ff[BIT_PRE_RUN];
    wire       buf_en   = channel_control_reg_ff[BIT_BUF_EN];
    wire       clr_en   = mode_select_reg_ff[BIT_CLR_MATCH];
    wire [2:0] clk_sel  = mode_select_reg_ff[POS_CLK_SEL +: 3];
    wire [1:0] cap_mode = mode_select_reg_ff[POS_CAP_MODE +: 2];

    // synchronised pin, edges read only from the second and third stage
    wire pin_rise = pin_sync_ff[1] & ~pin_sync_ff[2];
    wire pin_fall = ~pin_sync_ff[1] & pin_sync_ff[2];

    wire tick_pt1  = pre_run & ((presc_ff & (DIV_PT1 - 6'h01)) == (DIV_PT1 - 6'h01));
    wire tick_pt4  = pre_run & ((presc_ff & (DIV_PT4 - 6'h01)) == (DIV_PT4 - 6'h01));
    wire tick_pt16 = pre_run & ((presc_ff & (DIV_PT16 - 6'h01)) == (DIV_PT16 - 6'h01));
    wire tick = running & ((clk_sel == CLK_EXT_PIN) ? pin_rise :
                           (clk_sel == CLK_PT1)     ? tick_pt1 :
                           (clk_sel == CLK_PT4)     ? tick_pt4 :
                           (clk_sel == CLK_PT16)    ? tick_pt16 : 1'b0);

    wire eq0 = (up_counter_ff == compare_reg_zero_ff);
    wire eq1 = (up_counter_ff == compare_reg_one_ff);
    // one event per arrival at the compare value, not per cycle held
    wire match0 = running & eq0 & ~eq0_d_ff;
    wire match1 = running & eq1 & ~eq1_d_ff;

    // clear on match one
    // pending clear survives a buffer load that moves compare one away
    wire clr_now  = clr_en & (eq1 | clr_pend_ff);
    wire overflow = tick & ~clr_now & (up_counter_ff == 16'hffff);

    wire soft_cap = wr_mode & ~pwdata[BIT_SOFT_CAP];
    wire hw_cap0  = running & (cap_mode != CAPM_OFF) & pin_rise;
    wire hw_cap1  = running & ((cap_mode == CAPM_RISE_FALL) & pin_fall |
                               (cap_mode == CAPM_RISE_RISE) & pin_rise |
                               (cap_mode == CAPM_RISE_M1) & match1);
    wire cap0_ev  = soft_cap | hw_cap0;
    wire cap1_ev  = hw_cap1;

    wire [7:0] ffcr = toggle_flop_control_reg_ff;
    wire toggle_ev = (match0 & ffcr[BIT_E0T1]) | (match1 & ffcr[BIT_E1T1]) |
                     (cap0_ev & ffcr[BIT_C0T1]) | (cap1_ev & ffcr[BIT_C1T1]);
    wire [1:0] ff_cmd = pwdata[POS_FF_CTRL +: 2];

    wire direct    = ~running | ~buf_en;
    wire xfer      = running & buf_en & match1;

    logic [15:0] nxt_up_counter;
    always_comb begin
        nxt_up_counter = up_counter_ff;
        if (!running) begin
            nxt_up_counter = 16'h0000;
        end else if (tick) begin
            nxt_up_counter = clr_now ? 16'h0000 : up_counter_ff + 16'h0001;
        end
    end

    logic nxt_flop;
    always_comb begin
        nxt_flop = output_toggle_flop_ff;
        if (wr_ffcr && ff_cmd == FF_TOGGLE) begin
            nxt_flop = ~output_toggle_flop_ff;
        end else if (wr_ffcr && ff_cmd == FF_SET) begin
            nxt_flop = 1'b1;
        end else if (wr_ffcr && ff_cmd == FF_CLEAR) begin
            nxt_flop = 1'b0;
        end else if (toggle_ev) begin
            nxt_flop = ~output_toggle_flop_ff;
        end
    end

    logic [31:0] nxt_prdata;
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            OFF_ENABLE:  nxt_prdata[7:0]  = channel_enable_reg_ff;
            OFF_RUN:     nxt_prdata[7:0]  = run_control_reg_ff;
            OFF_CONTROL: nxt_prdata[7:0]  = channel_control_reg_ff;
            OFF_MODE:    nxt_prdata[7:0]  = mode_select_reg_ff;
            OFF_FFCR:    nxt_prdata[7:0]  = toggle_flop_control_reg_ff;
            OFF_CMP0:    nxt_prdata[15:0] = buf_en ? buffer_zero_ff : compare_reg_zero_ff;
            OFF_CMP1:    nxt_prdata[15:0] = buf_en ? buffer_one_ff : compare_reg_one_ff;
            OFF_CAP0:    nxt_prdata[15:0] = capture_reg_zero_ff;
            OFF_CAP1:    nxt_prdata[15:0] = capture_reg_one_ff;
            // live count, read has no side effect
            OFF_SNAP:    nxt_prdata[15:0] = up_counter_ff;
            default:     nxt_prdata = 32'h0000_0000;
        endcase
    end

    // apb: one wait-free access phase, pready raised from the setup cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            channel_enable_reg_ff      <= RST_ENABLE;
            run_control_reg_ff         <= RST_RUN;
            channel_control_reg_ff     <= RST_CONTROL;
            mode_select_reg_ff         <= RST_MODE;
            toggle_flop_control_reg_ff <= RST_FFCR;
        end else begin
            if (wr && paddr == OFF_ENABLE) begin
                channel_enable_reg_ff <= pwdata[7:0];
            end
            if (wr_run) begin
                run_control_reg_ff <= pwdata[7:0];
            end
            if (wr_ctl) begin
                channel_control_reg_ff <= pwdata[7:0];
            end
            if (wr_mode) begin
                mode_select_reg_ff <= pwdata[7:0] | 8'h40;
            end
            // control field reads back as no-change
            if (wr_ffcr) begin
                toggle_flop_control_reg_ff <= {pwdata[7:2], FF_SET | FF_CLEAR};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            compare_reg_zero_ff <= RST_CMP;
            compare_reg_one_ff  <= RST_CMP;
            buffer_zero_ff      <= RST_CMP;
            buffer_one_ff       <= RST_CMP;
        end else begin
            if (wr_cmp0) begin
                buffer_zero_ff <= pwdata[15:0];
            end
            if (wr_cmp1) begin
                buffer_one_ff <= pwdata[15:0];
            end
            if (wr_cmp0 && direct) begin
                compare_reg_zero_ff <= pwdata[15:0];
            end else if (xfer) begin
                compare_reg_zero_ff <= buffer_zero_ff;
            end
            if (wr_cmp1 && direct) begin
                compare_reg_one_ff <= pwdata[15:0];
            end else if (xfer) begin
                compare_reg_one_ff <= buffer_one_ff;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            up_counter_ff       <= 16'h0000;
            presc_ff            <= 6'h00;
            pin_sync_ff         <= 3'h0;
            eq0_d_ff            <= 1'b0;
            eq1_d_ff            <= 1'b0;
            capture_reg_zero_ff <= 16'h0000;
            capture_reg_one_ff  <= 16'h0000;
            clr_pend_ff         <= 1'b0;
        end else begin
            up_counter_ff <= nxt_up_counter;
            presc_ff      <= pre_run ? presc_ff + 6'h01 : 6'h00;
            pin_sync_ff   <= {pin_sync_ff[1:0], external_count_pin};
            eq0_d_ff      <= running & eq0;
            eq1_d_ff      <= running & eq1;
            clr_pend_ff   <= running & clr_en & ~tick & (match1 | clr_pend_ff);
            if (cap0_ev) begin
                capture_reg_zero_ff <= up_counter_ff;
            end
            if (cap1_ev) begin
                capture_reg_one_ff <= up_counter_ff;
            end
        end
    end

    // flop resets to zero, software sets polarity before use
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            output_toggle_flop_ff <= 1'b0;
            timer_output_pin      <= 1'b0;
            ovf_ff                <= 1'b0;
            cmp0_ff               <= 1'b0;
            cmp1_ff               <= 1'b0;
            cap0_ff               <= 1'b0;
            cap1_ff               <= 1'b0;
            cmp_any_ff            <= 1'b0;
        end else begin
            output_toggle_flop_ff <= nxt_flop;
            timer_output_pin      <= nxt_flop;
            ovf_ff                <= overflow;
            cmp0_ff               <= match0;
            cmp1_ff               <= match1;
            cap0_ff               <= cap0_ev;
            cap1_ff               <= cap1_ev;
            cmp_any_ff            <= match0 | match1;
        end
    end

    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign overflow_irq     = ovf_ff;
    assign compare_zero_irq = cmp0_ff;
    assign compare_one_irq  = cmp1_ff;
    assign capture_zero_irq = cap0_ff;
    assign capture_one_irq  = cap1_ff;

    assign compare_irq = cmp_any_ff;

    property p_stop_clears;
        @(posedge ref_clk) disable iff (!reset_n)
        wr_run & ~pwdata[BIT_RUN] |=> ##1 (up_counter_ff == 16'h0000);
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("counter not cleared after stop");

    property p_overflow;
        @(posedge ref_clk) disable iff (!reset_n)
        running & tick & ~clr_now & (up_counter_ff == 16'hffff)
            |=> overflow_irq & (up_counter_ff == 16'h0000);
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow did not wrap with interrupt");

    property p_match_irq;
        @(posedge ref_clk) disable iff (!reset_n)
        compare_irq |-> $past(running) & ($past(eq0) | $past(eq1));
    endproperty
    a_match_irq: assert property (p_match_irq)
        else $error("compare interrupt without match");

    property p_direct_write;
        @(posedge ref_clk) disable iff (!reset_n)
        wr_cmp0 & ~running |=> (compare_reg_zero_ff == $past(pwdata[15:0]));
    endproperty
    a_direct_write: assert property (p_direct_write)
        else $error("stopped compare write not immediate");

    property p_buffered_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        running & buf_en & ~match1 |=> $stable(compare_reg_one_ff);
    endproperty
    a_buffered_hold: assert property (p_buffered_hold)
        else $error("buffered compare changed without match");

    property p_soft_capture;
        @(posedge ref_clk) disable iff (!reset_n)
        soft_cap |=> (capture_reg_zero_ff == $past(up_counter_ff)) ##0 capture_zero_irq;
    endproperty
    a_soft_capture: assert property (p_soft_capture)
        else $error("soft capture missed");

    property p_ff_set;
        @(posedge ref_clk) disable iff (!reset_n)
        wr_ffcr & (ff_cmd == FF_SET) |=> output_toggle_flop_ff & timer_output_pin;
    endproperty
    a_ff_set: assert property (p_ff_set)
        else $error("flop set command failed");

    property p_toggle;
        @(posedge ref_clk) disable iff (!reset_n)
        toggle_ev & ~wr_ffcr |=> (output_toggle_flop_ff != $past(output_toggle_flop_ff));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("enabled event did not toggle flop");

    property p_event_count;
        @(posedge ref_clk) disable iff (!reset_n)
        running & (clk_sel == CLK_EXT_PIN) & ~pin_rise & ~wr_run |=> $stable(up_counter_ff);
    endproperty
    a_event_count: assert property (p_event_count)
        else $error("event counter moved without pin edge");

    property p_clear_match;
        @(posedge ref_clk) disable iff (!reset_n)
        running & tick & clr_en & eq1 |=> (up_counter_ff == 16'h0000);
    endproperty
    a_clear_match: assert property (p_clear_match)
        else $error("no clear on match one");

    property p_snapshot;
        @(posedge ref_clk) disable iff (!reset_n)
        setup & (paddr == OFF_SNAP) |=> (prdata[15:0] == $past(up_counter_ff)) & pready;
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("snapshot read wrong");
endmodule

// ===== tb/pin_source.sv
`timescale 1ns/100ps
module pin_source (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       go,
    input  wire logic [3:0] pulse_count,
    output logic            busy,
    output logic            pin
);
    logic [3:0] left_ff;
    logic [3:0] phase_ff;

    assign busy = (left_ff != 4'h0);

    // clean rising edges
    // pulses 6 cycles wide so the three-flop synchroniser never misses one
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            left_ff  <= 4'h0;
            phase_ff <= 4'h0;
            pin      <= 1'b0;
        end else if (go && !busy) begin
            left_ff  <= pulse_count;
            phase_ff <= 4'h0;
        end else if (busy) begin
            phase_ff <= phase_ff + 4'h1;
            if (phase_ff == 4'h5) begin
                pin <= 1'b1;
            end
            if (phase_ff == 4'hb) begin
                pin     <= 1'b0;
                left_ff <= left_ff - 4'h1;
            end
        end
    end
endmodule

// ===== tb/timer_capture_compare_ppg_test.sv
`timescale 1ns/100ps
module timer_capture_compare_ppg_test
    import timer_ccp_pkg::*;
;
    logic        ref_clk, reset_n, psel, penable, pwrite, go;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, external_count_pin, timer_output_pin, busy;
    logic        overflow_irq, compare_irq, compare_zero_irq, compare_one_irq;
    logic        capture_zero_irq, capture_one_irq;
    int          n_mismatch, check_count;
    wire  [6:0]  ev = {busy, capture_one_irq, compare_irq, timer_output_pin,
                       capture_zero_irq, compare_one_irq, compare_zero_irq};

    timer_capture_compare_ppg DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_pin(external_count_pin),
        .timer_output_pin(timer_output_pin), .overflow_irq(overflow_irq),
        .compare_irq(compare_irq), .compare_zero_irq(compare_zero_irq),
        .compare_one_irq(compare_one_irq), .capture_zero_irq(capture_zero_irq),
        .capture_one_irq(capture_one_irq));

    pin_source pin_model (
        .ref_clk(ref_clk), .reset_n(reset_n), .go(go), .pulse_count(4'h3),
        .busy(busy), .pin(external_count_pin));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop;
        if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic timeout;
        $display("ERROR %0t: wait ran out", $time);
        n_mismatch++;
        report_and_stop();
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int i;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
            if (i > 20) timeout();
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
    endtask

    // n counts falling edges up to and including the one that sees the level
    task automatic wait_ev(input int idx, input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (n > 3000) timeout();
        end while (ev[idx] !== lvl);
    endtask

    task automatic test_reset;
        logic [31:0] d;
        logic        e;
        rd_chk(OFF_CONTROL, 32'h0);
        rd_chk(OFF_MODE, 32'h40);
        rd_chk(OFF_FFCR, 32'h03);
        apb(1'b0, 12'h030, 32'h0, d, e);
        check({31'h0, e}, 32'h1);
        check(d, 32'h0);
        apb(1'b1, 12'h031, 32'hff, d, e);
        check({31'h0, e}, 32'h1);
        check({31'h0, timer_output_pin}, 32'h0);
    endtask

    task automatic test_flop;
        logic [1:0] ctl [4] = '{FF_SET, FF_CLEAR, FF_TOGGLE, FF_TOGGLE};
        logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            wr(OFF_FFCR, {30'h0, ctl[i]});
            repeat (2) @(negedge ref_clk);
            check({31'h0, timer_output_pin}, {31'h0, exp[i]});
        end
    endtask

    task automatic test_count;
        logic [31:0] a, b;
        logic        e;
        wr(OFF_ENABLE, 32'h80);
        wr(OFF_MODE, 32'h41);
        wr(OFF_RUN, 32'h05);
        apb(1'b0, OFF_SNAP, 32'h0, a, e);
        apb(1'b0, OFF_SNAP, 32'h0, b, e);
        // reads three cycles apart, one tick every two cycles
        check({31'h0, b > a && b - a <= 32'h2}, 32'h1);
        wr(OFF_RUN, 32'h0);
        rd_chk(OFF_SNAP, 32'h0);
    endtask

    task automatic test_interval;
        int n;
        wr(OFF_CMP0, 32'h5);
        wr(OFF_CMP1, 32'ha);
        wr(OFF_MODE, 32'h61);
        wr(OFF_RUN, 32'h05);
        wait_ev(0, 1'b1, n);
        wait_ev(1, 1'b1, n);
        check(32'(n), 32'd10);
        wait_ev(1, 1'b0, n);
        wait_ev(1, 1'b1, n);
        check(32'(n), 32'd21);
        wait_ev(0, 1'b0, n);
        wait_ev(0, 1'b1, n);
        check(32'(n), 32'd11);
        wait_ev(4, 1'b1, n);
        check({31'h0, n <= 22}, 32'h1);
        check({31'h0, overflow_irq}, 32'h0);
        wr(OFF_RUN, 32'h0);
    endtask

    task automatic test_buffer;
        int n;
        wr(OFF_CONTROL, 32'h80);
        wr(OFF_CMP1, 32'h8);
        wr(OFF_RUN, 32'h05);
        wait_ev(1, 1'b1, n);
        wait_ev(1, 1'b0, n);
        wait_ev(1, 1'b1, n);
        check(32'(n), 32'd17);
        wr(OFF_CMP1, 32'hc);
        wait_ev(1, 1'b1, n);
        wait_ev(1, 1'b0, n);
        wait_ev(1, 1'b1, n);
        check(32'(n), 32'd25);
        wr(OFF_RUN, 32'h0);
        wr(OFF_CONTROL, 32'h0);
    endtask

    task automatic test_ppg;
        int   n;
        logic lvl;
        wr(OFF_CMP0, 32'h4);
        wr(OFF_CMP1, 32'ha);
        wr(OFF_FFCR, 32'h0e);
        wr(OFF_RUN, 32'h05);
        wait_ev(3, 1'b1, n);
        wait_ev(3, 1'b0, n);
        check(32'(n), 32'd12);
        wait_ev(3, 1'b1, n);
        check(32'(n), 32'd10);
        wr(OFF_FFCR, 32'h03);
        lvl = timer_output_pin;
        repeat (50) @(negedge ref_clk);
        check({31'h0, timer_output_pin}, {31'h0, lvl});
        wr(OFF_RUN, 32'h0);
    endtask

    task automatic test_event;
        int n;
        wr(OFF_MODE, 32'h50);
        wr(OFF_RUN, 32'h05);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        wait_ev(2, 1'b1, n);
        check({31'h0, capture_one_irq}, 32'h1);
        wait_ev(6, 1'b0, n);
        repeat (8) @(negedge ref_clk);
        rd_chk(OFF_SNAP, 32'h3);
        wr(OFF_MODE, 32'h10);
        rd_chk(OFF_CAP0, 32'h3);
        // rise to capture zero, fall to capture one
        wr(OFF_MODE, 32'h48);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        wait_ev(5, 1'b1, n);
        check({31'h0, capture_zero_irq}, 32'h0);
        wait_ev(6, 1'b0, n);
        repeat (8) @(negedge ref_clk);
        rd_chk(OFF_CAP0, 32'h5);
        rd_chk(OFF_CAP1, 32'h6);
    endtask

    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        go = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        test_reset();
        test_flop();
        test_count();
        test_interval();
        test_buffer();
        test_ppg();
        test_event();
        report_and_stop();
    end
endmodule
